// >>> core/srtlu_core.sv
// Shift, rotate and table logic unit with its word memory and AHB-Lite slave.
// Assumes single word transfers, one clock, chain pins asynchronous to mclk_in.
module srtlu_core #(
  parameter int DEPTH = 64
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic chain_enable_in,
  input wire logic chain_shift_in,
  input wire logic chain_dir_in,
  output logic busy_out,
  output logic carry_out,
  output logic test_result_out
);
  import srtlu_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int EW = AW + 4;

  typedef enum {ST_IDLE, ST_EXEC, ST_TABLE, ST_WALK} srtlu_state_e;

  logic [WORD_W-1:0] mem [DEPTH];
  srtlu_state_e state, next_state;
  srtlu_op_e op;
  logic word_tgt;
  logic [OPR_W-1:0] opa, opb, opc, cnt, chain_base, chain_len;
  logic chain_bidir;
  logic dp_write;
  logic [11:0] dp_addr;
  logic [OPR_W-1:0] idx, passes, w_len;
  logic [EW-1:0] w_base;
  logic w_right, w_rot, w_word, w_carry;
  logic [WORD_W-1:0] hold;
  logic [2:0] sync_meta, sync_q;
  logic shift_prev, chain_pend;
  logic a_valid, reg_wr, start_op, chain_edge, chain_go;
  logic [31:0] rd_data;

  assign a_valid = hsel_in & htrans_in[1] & hready_in;
  assign reg_wr = dp_write & (state == ST_IDLE);
  assign start_op = reg_wr & (dp_addr == ADDR_OPCODE);
  assign chain_edge = sync_q[1] & ~shift_prev & sync_q[0];
  assign chain_go = chain_pend & (state == ST_IDLE) & ~start_op;

  // Element walker: one bit or one word moved per cycle
  logic [EW-1:0] pos_ea, src_ea;
  logic [WORD_W-1:0] pos_val, src_val, out_val, new_val;
  logic w_last;
  always_comb begin
    if (w_right) begin
      pos_ea = w_base + EW'(idx);
      src_ea = pos_ea + EW'(1);
    end else begin
      pos_ea = w_base + EW'(w_len - idx - 16'h0001);
      src_ea = pos_ea - EW'(1);
    end
    w_last = (idx == w_len - 16'h0001);
    if (w_word) begin
      pos_val = mem[pos_ea[AW-1:0]];
      src_val = mem[src_ea[AW-1:0]];
    end else begin
      pos_val = WORD_W'(mem[pos_ea[EW-1:4]][pos_ea[3:0]]);
      src_val = WORD_W'(mem[src_ea[EW-1:4]][src_ea[3:0]]);
    end
    // The element leaving the file is read before step 0 overwrites it
    out_val = (idx == RST_OPR) ? pos_val : hold;
    if (!w_last) begin
      new_val = src_val;
    end else if (w_rot) begin
      new_val = out_val;
    end else begin
      new_val = '0;
    end
  end

  // Table operand words
  logic [AW-1:0] ta, tb, tc;
  logic [WORD_W-1:0] tres;
  always_comb begin
    ta = opa[AW-1:0] + idx[AW-1:0];
    tb = opb[AW-1:0] + idx[AW-1:0];
    tc = opc[AW-1:0] + idx[AW-1:0];
    if (op == OP_TABLE_AND) begin
      tres = mem[ta] & mem[tb];
    end else if (op == OP_TABLE_OR) begin
      tres = mem[ta] | mem[tb];
    end else if (op == OP_TABLE_XOR) begin
      tres = mem[ta] ^ mem[tb];
    end else begin
      tres = ~(mem[ta] ^ mem[tb]);
    end
  end

  // Single-step decode for word shifts, tests and launches
  srtlu_shreq_s sh_req;
  srtlu_shres_s sh_res;
  logic one_bit, sh_op, tbl_op, file_op, bt_val;
  logic [WORD_W-1:0] a_word, a_next, b_word, b_next;
  logic [EW-1:0] bt_ea;
  always_comb begin
    one_bit = op inside {OP_SHIFT_RIGHT_1, OP_SHIFT_LEFT_1, OP_ROTATE_RIGHT_1,
                         OP_ROTATE_LEFT_1, OP_ROTATE_RIGHT_CARRY_1};
    sh_op = one_bit | (op inside {OP_SHIFT_RIGHT_N, OP_SHIFT_LEFT_N,
                                  OP_ROTATE_RIGHT_N, OP_ROTATE_LEFT_N});
    tbl_op = op inside {OP_TABLE_AND, OP_TABLE_OR, OP_TABLE_XOR, OP_TABLE_XNOR};
    file_op = op inside {OP_FILE_SHIFT_RIGHT, OP_FILE_SHIFT_LEFT,
                         OP_FILE_ROTATE_RIGHT, OP_FILE_ROTATE_LEFT};
    a_word = mem[opa[AW-1:0]];
    a_next = mem[opa[AW-1:0] + AW'(1)];
    b_word = mem[opb[AW-1:0]];
    b_next = mem[opb[AW-1:0] + AW'(1)];
    bt_ea = opb[EW-1:0] + EW'(a_word);
    bt_val = (a_word < cnt) ? mem[bt_ea[EW-1:4]][bt_ea[3:0]] : 1'b0;
    sh_req.word = a_word;
    sh_req.count = one_bit ? ONE_STEP : cnt[CNT_W-1:0];
    sh_req.carry = carry_out;
    if (op inside {OP_SHIFT_RIGHT_1, OP_SHIFT_RIGHT_N}) begin
      sh_req.kind = SH_RIGHT;
    end else if (op inside {OP_SHIFT_LEFT_1, OP_SHIFT_LEFT_N}) begin
      sh_req.kind = SH_LEFT;
    end else if (op inside {OP_ROTATE_RIGHT_1, OP_ROTATE_RIGHT_N}) begin
      sh_req.kind = RO_RIGHT;
    end else if (op == OP_ROTATE_RIGHT_CARRY_1) begin
      sh_req.kind = RC_RIGHT;
    end else begin
      sh_req.kind = RO_LEFT;
    end
  end

  srtlu_shifter u_shifter (
    .req_in(sh_req),
    .res_out(sh_res)
  );

  // Single memory write port
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [WORD_W-1:0] mem_wd;
  always_comb begin
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    unique case (state)
      ST_IDLE: begin
        if (reg_wr && dp_addr[11:10] == MEM_WINDOW) begin
          mem_we = 1'b1;
          mem_wa = dp_addr[AW+1:2];
          mem_wd = hwdata_in[WORD_W-1:0];
        end
      end
      ST_EXEC: begin
        if (sh_op) begin
          mem_we = 1'b1;
          mem_wa = one_bit ? opa[AW-1:0] : opc[AW-1:0];
          mem_wd = sh_res.word;
        end
      end
      ST_TABLE: begin
        mem_we = 1'b1;
        mem_wa = tc;
        mem_wd = tres;
      end
      ST_WALK: begin
        mem_we = 1'b1;
        if (w_word) begin
          mem_wa = pos_ea[AW-1:0];
          mem_wd = new_val;
        end else begin
          mem_wa = pos_ea[EW-1:4];
          mem_wd = mem[pos_ea[EW-1:4]];
          mem_wd[pos_ea[3:0]] = new_val[0];
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_op) begin
          next_state = ST_EXEC;
        end else if (chain_go && chain_len != RST_OPR) begin
          next_state = ST_WALK;
        end
      end
      ST_EXEC: begin
        if (tbl_op && cnt != RST_OPR) begin
          next_state = ST_TABLE;
        end else if (op == OP_DEVICE_SHIFT) begin
          next_state = ST_WALK;
        end else if (file_op && cnt != RST_OPR && a_word != RST_OPR) begin
          next_state = ST_WALK;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_TABLE: begin
        if (idx == cnt - 16'h0001) begin
          next_state = ST_IDLE;
        end
      end
      ST_WALK: begin
        if (w_last && passes == 16'h0001) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      busy_out <= 1'b0;
    end else begin
      state <= next_state;
      busy_out <= (next_state != ST_IDLE);
    end
  end

  // Loop counters and walk setup
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx <= RST_OPR;
      passes <= RST_OPR;
      w_len <= RST_OPR;
      w_base <= '0;
      w_right <= 1'b0;
      w_rot <= 1'b0;
      w_word <= 1'b0;
      w_carry <= 1'b0;
      hold <= '0;
    end else if (chain_go) begin
      idx <= RST_OPR;
      passes <= 16'h0001;
      w_len <= chain_len;
      w_base <= chain_base[EW-1:0];
      w_right <= chain_bidir & ~sync_q[2];
      w_rot <= 1'b0;
      w_word <= 1'b0;
      w_carry <= 1'b1;
    end else if (state == ST_EXEC) begin
      idx <= RST_OPR;
      if (op == OP_DEVICE_SHIFT) begin
        passes <= 16'h0001;
        w_len <= DEV_SHIFT_LEN;
        w_base <= opa[EW-1:0] - EW'(1);
        w_right <= 1'b0;
        w_rot <= 1'b0;
        w_word <= 1'b0;
        w_carry <= 1'b0;
      end else begin
        passes <= a_word;
        w_len <= cnt;
        w_base <= word_tgt ? EW'(opb[AW-1:0]) : opb[EW-1:0];
        w_right <= op inside {OP_FILE_SHIFT_RIGHT, OP_FILE_ROTATE_RIGHT};
        w_rot <= op inside {OP_FILE_ROTATE_RIGHT, OP_FILE_ROTATE_LEFT};
        w_word <= word_tgt;
        w_carry <= ~word_tgt;
      end
    end else if (state == ST_TABLE) begin
      idx <= idx + 16'h0001;
    end else if (state == ST_WALK) begin
      if (idx == RST_OPR) begin
        hold <= pos_val;
      end
      if (w_last) begin
        idx <= RST_OPR;
        passes <= passes - 16'h0001;
      end else begin
        idx <= idx + 16'h0001;
      end
    end
  end

  // Carry flag
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      carry_out <= 1'b0;
    end else if (reg_wr && dp_addr == ADDR_CARRY) begin
      carry_out <= hwdata_in[0];
    end else if (state == ST_EXEC && sh_op) begin
      carry_out <= sh_res.carry;
    end else if (state == ST_WALK && w_last && w_carry) begin
      carry_out <= out_val[0];
    end
  end

  // Test result
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      test_result_out <= 1'b0;
    end else if (state == ST_EXEC) begin
      if (op == OP_TEST) begin
        test_result_out <= |(a_word & b_word);
      end else if (op == OP_DOUBLE_TEST) begin
        test_result_out <= |({a_next, a_word} & {b_next, b_word});
      end else if (op == OP_BIT_TEST) begin
        test_result_out <= bt_val;
      end
    end
  end

  // Software registers, writable only while idle
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op <= OP_NOP;
      word_tgt <= 1'b0;
      opa <= RST_OPR;
      opb <= RST_OPR;
      opc <= RST_OPR;
      cnt <= RST_OPR;
      chain_base <= RST_OPR;
      chain_len <= RST_OPR;
      chain_bidir <= 1'b0;
    end else if (reg_wr) begin
      unique case (dp_addr)
        ADDR_OPCODE: begin
          op <= srtlu_op_e'(hwdata_in[4:0]);
          word_tgt <= hwdata_in[FLD_TARGET_WORD];
        end
        ADDR_OPER_A: opa <= hwdata_in[OPR_W-1:0];
        ADDR_OPER_B: opb <= hwdata_in[OPR_W-1:0];
        ADDR_OPER_C: opc <= hwdata_in[OPR_W-1:0];
        ADDR_COUNT: cnt <= hwdata_in[OPR_W-1:0];
        ADDR_CHAIN_BASE: chain_base <= hwdata_in[OPR_W-1:0];
        ADDR_CHAIN_LEN: begin
          chain_len <= hwdata_in[OPR_W-1:0];
          chain_bidir <= hwdata_in[FLD_CHAIN_BIDIR];
        end
        default: begin
        end
      endcase
    end
  end

  // Chain pins: two-stage synchroniser, then edge detect on the shift input
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_meta <= 3'h0;
      sync_q <= 3'h0;
      shift_prev <= 1'b0;
    end else begin
      sync_meta <= {chain_dir_in, chain_shift_in, chain_enable_in};
      sync_q <= sync_meta;
      shift_prev <= sync_q[1];
    end
  end

  // A new edge in the launch cycle stays pending
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chain_pend <= 1'b0;
    end else if (chain_edge) begin
      chain_pend <= 1'b1;
    end else if (chain_go) begin
      chain_pend <= 1'b0;
    end
  end

  // Read mux, sampled in the address phase
  always_comb begin
    rd_data = 32'h0000_0000;
    if (haddr_in[11:10] == MEM_WINDOW) begin
      rd_data[WORD_W-1:0] = mem[haddr_in[AW+1:2]];
    end else begin
      unique case (haddr_in[11:0])
        ADDR_OPCODE: begin
          rd_data[4:0] = op;
          rd_data[FLD_TARGET_WORD] = word_tgt;
        end
        ADDR_OPER_A: rd_data[OPR_W-1:0] = opa;
        ADDR_OPER_B: rd_data[OPR_W-1:0] = opb;
        ADDR_OPER_C: rd_data[OPR_W-1:0] = opc;
        ADDR_COUNT: rd_data[OPR_W-1:0] = cnt;
        ADDR_STATUS: begin
          rd_data[STAT_BUSY] = busy_out;
          rd_data[STAT_CARRY] = carry_out;
          rd_data[STAT_TEST] = test_result_out;
          rd_data[STAT_PEND] = chain_pend;
        end
        ADDR_CARRY: rd_data[0] = carry_out;
        ADDR_CHAIN_BASE: rd_data[OPR_W-1:0] = chain_base;
        ADDR_CHAIN_LEN: begin
          rd_data[OPR_W-1:0] = chain_len;
          rd_data[FLD_CHAIN_BIDIR] = chain_bidir;
        end
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      dp_write <= a_valid & hwrite_in;
      dp_addr <= haddr_in[11:0];
      hrdata_out <= (a_valid && !hwrite_in) ? rd_data : 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end
endmodule // srtlu_core

// >>> core/srtlu_pkg.sv
// Constants and carrier types for the shift, rotate and table logic unit.
// Assumes one clock domain and software access over an AHB-Lite slave port.
// Functional notes
// - Table AND writes n word results
// - Table OR writes n word results
// - Table XOR writes n word results
// - Table XNOR writes n word results
// - Test flag set when word AND nonzero
// - Double test over two-word pairs
// - Bit test selects indexed bit in table
// - One-bit shift in place, carry updated
// - N-bit shift to destination, carry updated
// - Device shift copies lower bit, clears it
// - Enabled chain shifts n bits upward
// - Bidirectional chain direction chosen by input
// - Bit file shift by count, carry updated
// - Word table shift by count
// - One-bit rotate in place, carry updated
// - Rotate right through carry
// - N-bit rotate to destination, carry updated
// - Word table rotate by count
// - Bit file rotate by count, carry updated
package srtlu_pkg;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int OPR_W = 16;
  localparam logic [11:0] ADDR_OPCODE = 12'h000;
  localparam logic [11:0] ADDR_OPER_A = 12'h004;
  localparam logic [11:0] ADDR_OPER_B = 12'h008;
  localparam logic [11:0] ADDR_OPER_C = 12'h00C;
  localparam logic [11:0] ADDR_COUNT = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_CARRY = 12'h018;
  localparam logic [11:0] ADDR_CHAIN_BASE = 12'h01C;
  localparam logic [11:0] ADDR_CHAIN_LEN = 12'h020;
  localparam logic [1:0] MEM_WINDOW = 2'h1;
  localparam int FLD_TARGET_WORD = 8;
  localparam int FLD_CHAIN_BIDIR = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CARRY = 1;
  localparam int STAT_TEST = 2;
  localparam int STAT_PEND = 3;
  localparam logic [OPR_W-1:0] RST_OPR = 16'h0000;
  localparam logic [CNT_W-1:0] ONE_STEP = 5'h01;
  localparam logic [OPR_W-1:0] DEV_SHIFT_LEN = 16'h0002;

  typedef enum logic [4:0] {
    OP_NOP, OP_TABLE_AND, OP_TABLE_OR, OP_TABLE_XOR, OP_TABLE_XNOR,
    OP_TEST, OP_DOUBLE_TEST, OP_BIT_TEST,
    OP_SHIFT_RIGHT_1, OP_SHIFT_LEFT_1, OP_SHIFT_RIGHT_N, OP_SHIFT_LEFT_N,
    OP_DEVICE_SHIFT, OP_FILE_SHIFT_RIGHT, OP_FILE_SHIFT_LEFT,
    OP_ROTATE_RIGHT_1, OP_ROTATE_LEFT_1, OP_ROTATE_RIGHT_CARRY_1,
    OP_ROTATE_RIGHT_N, OP_ROTATE_LEFT_N, OP_FILE_ROTATE_RIGHT, OP_FILE_ROTATE_LEFT
  } srtlu_op_e;

  typedef enum logic [2:0] {SH_RIGHT, SH_LEFT, RO_RIGHT, RO_LEFT, RC_RIGHT} srtlu_kind_e;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [CNT_W-1:0] count;
    srtlu_kind_e kind;
    logic carry;
  } srtlu_shreq_s;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic carry;
  } srtlu_shres_s;
endpackage

// >>> core/srtlu_shifter.sv
// Combinational word shifter and rotator for counts 0 to 31.
// Assumes the caller registers the result.
module srtlu_shifter (
  input wire srtlu_pkg::srtlu_shreq_s req_in,
  output srtlu_pkg::srtlu_shres_s res_out
);
  import srtlu_pkg::*;

  always_comb begin
    logic [WORD_W-1:0] w;
    logic c;
    w = req_in.word;
    c = req_in.carry;
    // A zero count leaves word and carry as given
    for (int i = 0; i < (1 << CNT_W); i++) begin
      if (i < int'(req_in.count)) begin
        unique case (req_in.kind)
          SH_RIGHT: begin
            c = w[0];
            w = {1'b0, w[WORD_W-1:1]};
          end
          SH_LEFT: begin
            c = w[WORD_W-1];
            w = {w[WORD_W-2:0], 1'b0};
          end
          RO_RIGHT: begin
            c = w[0];
            w = {w[0], w[WORD_W-1:1]};
          end
          RO_LEFT: begin
            c = w[WORD_W-1];
            w = {w[WORD_W-2:0], w[WORD_W-1]};
          end
          RC_RIGHT: begin
            {w, c} = {c, w};
          end
          default: begin
            c = req_in.carry;
          end
        endcase
      end
    end
    res_out.word = w;
    res_out.carry = c;
  end
endmodule // srtlu_shifter

// >>> test/srtlu_chain_partner.sv
// Model of the sequencer side that drives the shift chain pins.
// Assumes the caller starts a pulse just after a rising clock edge.
module srtlu_chain_partner (
  input wire logic mclk_in,
  output logic chain_enable_out,
  output logic chain_shift_out,
  output logic chain_dir_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chain_enable_out <= 1'b0;
    chain_shift_out <= 1'b0;
    chain_dir_out <= 1'b0;
  end
  // Each level held four clocks so the synchroniser sees it
  task automatic pulse(input logic en, input logic dir);
    chain_enable_out <= en;
    chain_dir_out <= dir;
    repeat (4) @(posedge mclk_in);
    chain_shift_out <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chain_shift_out <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chain_enable_out <= 1'b0;
  endtask
endmodule // srtlu_chain_partner

// >>> test/srtlu_core_checker.sv
// Concurrent checks on the bus, status and chain ports of the unit.
// Assumes it is bound into srtlu_core and sees one clock domain.
module srtlu_core_checker #(
  parameter int DEPTH = 64
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic chain_enable_in,
  input wire logic chain_shift_in,
  input wire logic busy_out,
  input wire logic carry_out,
  input wire logic test_result_out
);
  import srtlu_pkg::*;
  logic aph;
  logic aph_wr_opc;
  logic aph_wr_carry;
  assign aph = hsel_in && htrans_in[1] && hready_in;
  assign aph_wr_opc = aph && hwrite_in && (haddr_in[11:0] == ADDR_OPCODE);
  assign aph_wr_carry = aph && hwrite_in && (haddr_in[11:0] == ADDR_CARRY);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Opcode write accepted while idle, then one execute cycle
  sequence s_test_start;
    (aph_wr_opc && !busy_out) ##1 (hwdata_in[4:0] == OP_TEST);
  endsequence
  sequence s_one_busy;
    busy_out ##1 !busy_out;
  endsequence
  property p_test_busy;
    s_test_start |-> ##1 s_one_busy;
  endproperty
  property p_ready;
    hreadyout_out && !hresp_out;
  endproperty
  property p_rdata_idle;
    !$past(aph) |-> hrdata_out == 32'h0;
  endproperty
  property p_rdata_hi;
    hrdata_out[31:17] == 15'h0;
  endproperty
  property p_carry_cause;
    $changed(carry_out) |-> $past(busy_out) || $past(aph_wr_carry, 2);
  endproperty
  property p_test_cause;
    $changed(test_result_out) |-> $past(busy_out);
  endproperty
  property p_busy_ends;
    busy_out |-> ##[1:1000] !busy_out;
  endproperty
  property p_chain_go;
    $rose(chain_shift_in) && chain_enable_in && !busy_out |-> ##[2:8] busy_out;
  endproperty
  property p_chain_off;
    $rose(chain_shift_in) && !chain_enable_in && !busy_out |-> ##1 !busy_out [*8];
  endproperty
  a_test_busy: assert property (p_test_busy)
    else $error("test op busy span wrong");
  a_ready: assert property (p_ready)
    else $error("bus ready or response wrong");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside data phase");
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("read data upper bits not zero");
  a_carry_cause: assert property (p_carry_cause)
    else $error("carry changed without cause");
  a_test_cause: assert property (p_test_cause)
    else $error("test result changed without operation");
  a_busy_ends: assert property (p_busy_ends)
    else $error("busy never ends");
  a_chain_go: assert property (p_chain_go)
    else $error("chain shift not launched");
  a_chain_off: assert property (p_chain_off)
    else $error("chain shift launched while disabled");
endmodule // srtlu_core_checker

bind srtlu_core srtlu_core_checker #(.DEPTH(DEPTH)) u_chk (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .chain_enable_in(chain_enable_in), .chain_shift_in(chain_shift_in),
  .busy_out(busy_out), .carry_out(carry_out), .test_result_out(test_result_out)
);

// >>> test/tb_shift_rotate_table_logic_unit.sv
// Testbench: AHB-Lite register tasks, then operation sequences with expected values.
// Assumes srtlu_core with 64 words and the chain partner model.
module tb_shift_rotate_table_logic_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import srtlu_pkg::*;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic busy_out, carry_out, test_out, c_en, c_sh, c_dir;
  logic [31:0] rv;
  logic [16:0] e;
  int n_fail = 0;
  int total_checks = 0;
  logic [4:0] sops[10] = '{OP_SHIFT_RIGHT_1, OP_SHIFT_LEFT_1, OP_SHIFT_RIGHT_N,
    OP_SHIFT_LEFT_N, OP_SHIFT_RIGHT_N, OP_ROTATE_RIGHT_1, OP_ROTATE_LEFT_1,
    OP_ROTATE_RIGHT_CARRY_1, OP_ROTATE_RIGHT_N, OP_ROTATE_LEFT_N};
  int scnt[10] = '{1, 1, 5, 16, 0, 1, 1, 1, 31, 16};

  srtlu_core #(.DEPTH(64)) dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .chain_enable_in(c_en), .chain_shift_in(c_sh), .chain_dir_in(c_dir),
    .busy_out(busy_out), .carry_out(carry_out), .test_result_out(test_out)
  );
  srtlu_chain_partner u_par (
    .mclk_in(mclk_in), .chain_enable_out(c_en), .chain_shift_out(c_sh),
    .chain_dir_out(c_dir)
  );

  initial begin
    forever #50 mclk_in = ~mclk_in;
  end

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk_in);
    while (hready !== 1'b1) @(posedge mclk_in);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk_in);
    while (hready !== 1'b1) @(posedge mclk_in);
    rv = hrdata;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    xfer(a, 1'b0, 32'h0);
    chk(nm, ex, rv);
  endtask

  task mw(input int i, input logic [15:0] d);
    wr(12'h400 + 12'(4 * i), {16'h0, d});
  endtask

  task mchk(input int i, input logic [15:0] ex);
    rchk("memory word", 12'h400 + 12'(4 * i), {16'h0, ex});
  endtask

  task stat(input int b, input logic ex);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk("status bit", {31'h0, ex}, {31'h0, rv[b]});
    if (b == STAT_CARRY) chk("carry pin", {31'h0, ex}, {31'h0, carry_out});
    if (b == STAT_TEST) chk("test pin", {31'h0, ex}, {31'h0, test_out});
  endtask

  task wait_idle();
    int t;
    t = 0;
    @(posedge mclk_in);
    @(posedge mclk_in);
    while (busy_out === 1'b1 && t < 3000) begin
      @(posedge mclk_in);
      t++;
    end
    // A wait that runs out counts as a mismatch
    chk("busy", 32'h0, {31'h0, busy_out});
  endtask

  task run(input logic [8:0] op, input logic [15:0] a, b, c, n);
    wr(ADDR_OPER_A, {16'h0, a});
    wr(ADDR_OPER_B, {16'h0, b});
    wr(ADDR_OPER_C, {16'h0, c});
    wr(ADDR_COUNT, {16'h0, n});
    wr(ADDR_OPCODE, {23'h0, op});
    wait_idle();
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [16:0] sh(input logic [4:0] op, input logic [15:0] w,
                                     input int n, input logic c);
    for (int i = 0; i < n; i++) begin
      case (op)
        OP_SHIFT_RIGHT_1, OP_SHIFT_RIGHT_N: {w, c} = {1'b0, w};
        OP_SHIFT_LEFT_1, OP_SHIFT_LEFT_N: {c, w} = {w, 1'b0};
        OP_ROTATE_RIGHT_1, OP_ROTATE_RIGHT_N: {w, c} = {w[0], w[15:1], w[0]};
        OP_ROTATE_LEFT_1, OP_ROTATE_LEFT_N: {c, w} = {w[15], w[14:0], w[15]};
        default: {w, c} = {c, w};
      endcase
    end
    return {c, w};
  endfunction

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    rchk("status", ADDR_STATUS, 32'h0);
    rchk("carry", ADDR_CARRY, 32'h0);
    rchk("unmapped", 12'h3F0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      mw(8 + i, 16'hF0C3 ^ 16'(i * 16'h1111));
      mw(12 + i, 16'hAA55 + 16'(i));
    end
    for (int op = 1; op <= 4; op++) begin
      mw(19, 16'h5A5A);
      run(9'(op), 8, 12, 16, 3);
      for (int i = 0; i < 3; i++) begin
        rv[15:0] = 16'hF0C3 ^ 16'(i * 16'h1111);
        e[15:0] = 16'hAA55 + 16'(i);
        case (op)
          1: e[15:0] = rv[15:0] & e[15:0];
          2: e[15:0] = rv[15:0] | e[15:0];
          3: e[15:0] = rv[15:0] ^ e[15:0];
          default: e[15:0] = ~(rv[15:0] ^ e[15:0]);
        endcase
        mchk(16 + i, e[15:0]);
      end
      mchk(19, 16'h5A5A);
    end
    mw(0, 16'h00F0);
    mw(1, 16'h0F10);
    run(OP_TEST, 0, 1, 0, 0);
    stat(STAT_TEST, 1'b1);
    mw(1, 16'h0F0F);
    run(OP_TEST, 0, 1, 0, 0);
    stat(STAT_TEST, 1'b0);
    mw(0, 16'h0000);
    mw(1, 16'h8000);
    mw(2, 16'hFFFF);
    mw(3, 16'h8000);
    run(OP_DOUBLE_TEST, 0, 2, 0, 0);
    stat(STAT_TEST, 1'b1);
    mw(3, 16'h7FFF);
    run(OP_DOUBLE_TEST, 0, 2, 0, 0);
    stat(STAT_TEST, 1'b0);
    mw(0, 16'h0005);
    mw(1, 16'h0220);
    run(OP_BIT_TEST, 0, 16, 0, 8);
    stat(STAT_TEST, 1'b1);
    mw(0, 16'h0009);
    run(OP_BIT_TEST, 0, 16, 0, 8);
    stat(STAT_TEST, 1'b0);
    for (int i = 0; i < 10; i++) begin
      mw(0, 16'hA5C3);
      mw(1, 16'h1111);
      wr(ADDR_CARRY, {31'h0, i[0]});
      run(9'(sops[i]), 0, 0, 1, 16'(scnt[i]));
      e = sh(sops[i], 16'hA5C3, scnt[i], i[0]);
      mchk(((sops[i] inside {OP_SHIFT_RIGHT_N, OP_SHIFT_LEFT_N, OP_ROTATE_RIGHT_N,
        OP_ROTATE_LEFT_N}) ? 1 : 0), e[15:0]);
      stat(STAT_CARRY, e[16]);
    end
    mw(2, 16'h0001);
    run(OP_DEVICE_SHIFT, 33, 0, 0, 0);
    mchk(2, 16'h0002);
    mw(0, 16'h0002);
    mw(3, 16'hF0B5);
    wr(ADDR_CARRY, 32'h1);
    run(OP_FILE_SHIFT_RIGHT, 0, 48, 0, 8);
    mchk(3, 16'hF02D);
    stat(STAT_CARRY, 1'b0);
    mw(0, 16'h0001);
    for (int i = 4; i < 8; i++) mw(i, 16'(i - 3));
    run({1'b1, 3'h0, OP_FILE_ROTATE_LEFT}, 0, 4, 0, 3);
    mchk(4, 16'h0003);
    mchk(5, 16'h0001);
    mchk(7, 16'h0004);
    run({1'b1, 3'h0, OP_FILE_SHIFT_RIGHT}, 0, 4, 0, 3);
    mchk(4, 16'h0001);
    mchk(6, 16'h0000);
    mw(2, 16'h8001);
    wr(ADDR_CHAIN_BASE, 32'h20);
    wr(ADDR_CHAIN_LEN, 32'h10);
    u_par.pulse(1'b1, 1'b0);
    wait_idle();
    mchk(2, 16'h0002);
    stat(STAT_CARRY, 1'b1);
    u_par.pulse(1'b0, 1'b1);
    wait_idle();
    mchk(2, 16'h0002);
    wr(ADDR_CHAIN_LEN, 32'h10010);
    u_par.pulse(1'b1, 1'b0);
    wait_idle();
    mchk(2, 16'h0001);
    stat(STAT_CARRY, 1'b0);
    u_par.pulse(1'b1, 1'b1);
    wait_idle();
    mchk(2, 16'h0002);
    stop_test();
  end
endmodule // tb_shift_rotate_table_logic_unit
